// file: design/flic_pkg.sv
package flic_pkg;

  // Source slots, also the fixed tie-break order (lower wins)
  localparam int NUM_SRC      = 11;
  localparam int SRC_EXT0     = 0;
  localparam int SRC_TMR0     = 1;
  localparam int SRC_EXT1     = 2;
  localparam int SRC_TMR1     = 3;
  localparam int SRC_SERIAL   = 4;
  localparam int SRC_BROWNOUT = 5;
  localparam int SRC_TWOWIRE  = 6;
  localparam int SRC_KEYPAD   = 7;
  localparam int SRC_TMR2     = 8;
  localparam int SRC_WDOG     = 9;
  localparam int SRC_CAPTURE  = 10;

  // Flag positions in the status vector
  localparam int NUM_FLAG     = 13;
  localparam int FLG_EXT0     = 0;
  localparam int FLG_TMR0     = 1;
  localparam int FLG_EXT1     = 2;
  localparam int FLG_TMR1     = 3;
  localparam int FLG_RX       = 4;
  localparam int FLG_TX       = 5;
  localparam int FLG_BROWNOUT = 6;
  localparam int FLG_TWSTATE  = 7;
  localparam int FLG_TWTOUT   = 8;
  localparam int FLG_KEYPAD   = 9;
  localparam int FLG_TMR2     = 10;
  localparam int FLG_WDOG     = 11;
  localparam int FLG_CAPTURE  = 12;

  // Sampled pin positions
  localparam int NUM_KEY      = 8;
  localparam int NUM_PIN      = 11;
  localparam int PIN_EXT0     = 0;
  localparam int PIN_EXT1     = 1;
  localparam int PIN_BROWNOUT = 2;
  localparam int PIN_KEY0     = 3;

  // Priority levels
  localparam int LVL_W        = 2;
  localparam int NUM_LVL      = 4;

  // Reset values
  localparam logic [NUM_PIN-1:0]  PIN_RST   = 11'h7fb;
  localparam logic [NUM_FLAG-1:0] FLAG_RST  = 13'h0000;
  localparam logic [NUM_LVL-1:0]  SVC_RST   = 4'h0;
  localparam logic [15:0]         VEC_RST   = 16'h0000;
  localparam logic                TRIG_EDGE = 1'h1;

  // Vector addresses
  localparam logic [15:0] VEC_EXT0     = 16'h0003;
  localparam logic [15:0] VEC_TMR0     = 16'h000b;
  localparam logic [15:0] VEC_EXT1     = 16'h0013;
  localparam logic [15:0] VEC_TMR1     = 16'h001b;
  localparam logic [15:0] VEC_SERIAL   = 16'h0023;
  localparam logic [15:0] VEC_BROWNOUT = 16'h002b;
  localparam logic [15:0] VEC_TWOWIRE  = 16'h0033;
  localparam logic [15:0] VEC_KEYPAD   = 16'h003b;
  localparam logic [15:0] VEC_TMR2     = 16'h0043;
  localparam logic [15:0] VEC_SPARE0   = 16'h004b;
  localparam logic [15:0] VEC_WDOG     = 16'h0053;
  localparam logic [15:0] VEC_SPARE1   = 16'h005b;
  localparam logic [15:0] VEC_CAPTURE  = 16'h0063;

  typedef logic [3:0] flic_idx_t;

  // Slot to vector; spare slots are never produced
  function automatic logic [15:0] flic_vector(input flic_idx_t idx);
    case (idx)
      4'h0:    flic_vector = VEC_EXT0;
      4'h1:    flic_vector = VEC_TMR0;
      4'h2:    flic_vector = VEC_EXT1;
      4'h3:    flic_vector = VEC_TMR1;
      4'h4:    flic_vector = VEC_SERIAL;
      4'h5:    flic_vector = VEC_BROWNOUT;
      4'h6:    flic_vector = VEC_TWOWIRE;
      4'h7:    flic_vector = VEC_KEYPAD;
      4'h8:    flic_vector = VEC_TMR2;
      4'h9:    flic_vector = VEC_WDOG;
      4'ha:    flic_vector = VEC_CAPTURE;
      default: flic_vector = VEC_RST;
    endcase
  endfunction

endpackage

// file: design/flic_res_if.sv
`timescale 1ns/1ps
// Requests out to the resolver, winner back
interface flic_res_if;
  logic [10:0]     req;        // Enabled pending requests
  logic [21:0]     lvl;        // Two level bits per source
  logic [1:0]      floorLvl;   // Highest level in service
  logic            floorValid; // Any level in service
  logic            hit;        // Winner may preempt
  logic [3:0]      hitIdx;     // Winning slot
  logic [1:0]      hitLvl;     // Winning level
  modport ctl (output req, lvl, floorLvl, floorValid, input hit, hitIdx, hitLvl);
  modport res (input req, lvl, floorLvl, floorValid, output hit, hitIdx, hitLvl);
endinterface

// file: design/flic_resolver.sv
`timescale 1ns/1ps
// Pure combinational arbiter; no state of its own
module flic_resolver (
  flic_res_if.res bus
);

  logic       found;
  logic [1:0] bestLvl;
  logic [3:0] bestIdx;

  // Walk downward so equal levels fall to the lowest slot
  always_comb begin
    found   = 1'b0;
    bestLvl = 2'h0;
    bestIdx = 4'h0;
    for (int i = flic_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (bus.req[i] && (!found || bus.lvl[2*i +: 2] >= bestLvl)) begin
        found   = 1'b1;
        bestLvl = bus.lvl[2*i +: 2];
        bestIdx = 4'(i);
      end
    end
  end

  // Only a strictly higher level may break into service
  always_comb begin
    bus.hit    = found && (!bus.floorValid || bestLvl > bus.floorLvl);
    bus.hitIdx = bestIdx;
    bus.hitLvl = bestLvl;
  end

endmodule

// file: design/flic_sampler.sv
`timescale 1ns/1ps
// Synchronises pins and samples them once per machine cycle
module flic_sampler (
  input  wire logic        clk,
  input  wire logic        rstSyncB,
  input  wire logic        clkEn,
  input  wire logic        machCycle,
  input  wire logic [10:0] pinIn,
  output logic      [10:0] sampled,
  output logic      [10:0] fall
);

  typedef struct packed {
    logic [10:0] sync1;  // First stage, read only by second
    logic [10:0] sync2;  // Safe copy
    logic [10:0] sample; // Value at last machine cycle
    logic [10:0] fall;   // High-then-low seen, one pulse
  } flic_smp_s;

  flic_smp_s q;
  flic_smp_s d;

  // Sample on machine cycle; compare with the previous sample
  always_comb begin
    d       = q;
    d.sync1 = pinIn;
    d.sync2 = q.sync1;
    d.fall  = 11'h000;
    if (machCycle) begin
      d.sample = q.sync2;
      d.fall   = q.sample & ~q.sync2;
    end
  end

  // Idle-high reset, brownout low, so a pin high at start is no edge
  always_ff @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      q <= '{flic_pkg::PIN_RST, flic_pkg::PIN_RST, flic_pkg::PIN_RST, 11'h000};
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign sampled = q.sample;
  assign fall    = q.fall;

endmodule

// file: design/flic_top.sv
`timescale 1ns/1ps
// What this block does
// - Eleven sources, four levels, global enable
// - External pins selectable edge or level
// - Edge: high sample then low sets
// - Edge flag cleared on vectoring
// - Level flag not cleared; re-requests
// - Timer 0/1 overflow flags, auto-cleared
// - Watchdog flag, gated by its enable
// - Timer 2 flag, never hardware-cleared
// - Serial receive/transmit flags, software cleared
// - Two-wire state flag, needs both enables
// - Enabled keypad press sets keyboard flag
// - Capture flag, own enable, software cleared
// - Brownout needs select, enable, global
// - Vectors 0003 and 000b
// - Vectors 0013 and 001b
// - Vectors 0023 and 002b
// - Vectors 0033 and 003b
// - Timer 2 0043; 004b spare
// - Watchdog 0053; 005b spare
// - Two-wire timeout also requests, software cleared
module flic_top (
  // Clock, reset, stall
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  // Machine-cycle strobe
  input  wire logic        machCycle,
  // External pins, trigger types
  input  wire logic        extIrqPinZero,
  input  wire logic        extIrqPinOne,
  input  wire logic        extZeroTriggerType,
  input  wire logic        extOneTriggerType,
  // Keypad lines, enables
  input  wire logic [7:0]  keypadPins,
  input  wire logic [7:0]  keypadIrqEnable,
  // Brownout, high = supply low
  input  wire logic        brownoutDetect,
  input  wire logic        brownoutIrqSelect,
  // Peripheral event pulses
  input  wire logic        timerZeroOverflow,
  input  wire logic        timerOneOverflow,
  input  wire logic        timerTwoEvent,
  input  wire logic        watchdogTimeout,
  input  wire logic        serialReceiveDone,
  input  wire logic        serialTransmitDone,
  input  wire logic        twowireStatusNew,
  input  wire logic        twowireCounterOverflow,
  input  wire logic        captureEvent,
  // Enables and priorities
  input  wire logic        globalIrqEnable,
  input  wire logic [10:0] srcIrqEnable,
  input  wire logic [10:0] prioLow,
  input  wire logic [10:0] prioHigh,
  // Software clears
  input  wire logic [12:0] flagSwClear,
  // Core handshake
  input  wire logic        irqAck,
  input  wire logic        irqReturn,
  // Offer and status
  output logic             irqReq,
  output logic      [15:0] irqVector,
  output logic      [1:0]  irqLevel,
  output logic      [12:0] irqFlags,
  output logic      [3:0]  inServiceLevels
);

  // Whole controller state in one record
  // Filled whole, registered once
  typedef struct packed {
    logic [12:0] flags; // Request flags
    logic [3:0]  inSvc; // One bit per level in service
    logic        req;   // Request to the core
    logic [15:0] vec;   // Offered vector
    logic [1:0]  lvl;   // Level of the offered source
    logic [3:0]  idx;   // Slot of the offered source
  } flic_top_s;

  flic_top_s   q;
  flic_top_s   d;
  logic [1:0]  rstPipe;  // Reset release stages
  logic        rstSyncB; // Released reset for all logic
  logic [10:0] pinIn;    // Raw pins to the sampler
  logic [10:0] sampled;  // Machine-cycle samples
  logic [10:0] fall;     // Falling-edge pulses
  logic [10:0] rawReq;   // Pending before enables
  logic [12:0] hwClear;  // Clears caused by vectoring
  logic [12:0] setEv;    // Hardware set events
  logic        ackTake;  // Core took the offered vector
  logic [3:0]  svcNext;  // In-service after return
  logic        keyPress; // Any enabled keypad press

  // Link to the resolver
  flic_res_if resBus ();

  // Assert at once, release two edges later
  // Only the pipe sees the raw reset, so
  // no release splits the state in two
  // Not frozen: reset always completes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  // Copy for every other process
  assign rstSyncB = rstPipe[1];

  // Pins from outside pass two flops before use
  // Order: pins, brownout, keys
  assign pinIn = {keypadPins, brownoutDetect, extIrqPinOne, extIrqPinZero};

  // Level samples feed level mode
  // Pin widths must last a machine cycle to be seen
  flic_sampler u_sampler (
    .clk       (ref_clk),
    .rstSyncB  (rstSyncB),
    .clkEn     (clkEn),
    .machCycle (machCycle),
    .pinIn     (pinIn),
    .sampled   (sampled),
    .fall      (fall)
  );

  // Winner pick from current state
  flic_resolver u_resolver (
    .bus (resBus)
  );

  // Keypad presses count only on enabled lines
  // One shared flag; line enables gate
  // the set, the slot enable the request
  assign keyPress = |(fall[flic_pkg::PIN_KEY0 +: flic_pkg::NUM_KEY] & keypadIrqEnable);

  // Collect hardware set events
  // Same-clock pulses need no sync
  // A held level sets every cycle
  always_comb begin
    setEv = 13'h0000;
    // Falling-edge pulses
    setEv[flic_pkg::FLG_EXT0]     = fall[flic_pkg::PIN_EXT0];
    setEv[flic_pkg::FLG_EXT1]     = fall[flic_pkg::PIN_EXT1];
    // Peripheral pulses
    setEv[flic_pkg::FLG_TMR0]     = timerZeroOverflow;
    setEv[flic_pkg::FLG_TMR1]     = timerOneOverflow;
    setEv[flic_pkg::FLG_RX]       = serialReceiveDone;
    setEv[flic_pkg::FLG_TX]       = serialTransmitDone;
    // Set while detector reads high
    setEv[flic_pkg::FLG_BROWNOUT] = sampled[flic_pkg::PIN_BROWNOUT];
    setEv[flic_pkg::FLG_TWSTATE]  = twowireStatusNew;
    setEv[flic_pkg::FLG_TWTOUT]   = twowireCounterOverflow;
    setEv[flic_pkg::FLG_KEYPAD]   = keyPress;
    setEv[flic_pkg::FLG_TMR2]     = timerTwoEvent;
    setEv[flic_pkg::FLG_WDOG]     = watchdogTimeout;
    setEv[flic_pkg::FLG_CAPTURE]  = captureEvent;
  end

  // Offer taken only while a request stands
  // Ack on a dropped offer is ignored
  assign ackTake = irqAck && q.req;

  // Flags that vectoring clears, by source policy
  // Only edge pins and timers 0/1 here
  // Uses the offered slot, not the winner
  always_comb begin
    hwClear = 13'h0000;
    if (ackTake) begin
      case (q.idx)
        // Pin zero, edge only
        4'h0: begin
          hwClear[flic_pkg::FLG_EXT0] = extZeroTriggerType == flic_pkg::TRIG_EDGE;
        end
        // Timer 0
        4'h1: begin
          hwClear[flic_pkg::FLG_TMR0] = 1'b1;
        end
        // Pin one, edge only
        4'h2: begin
          hwClear[flic_pkg::FLG_EXT1] = extOneTriggerType == flic_pkg::TRIG_EDGE;
        end
        // Timer 1
        4'h3: begin
          hwClear[flic_pkg::FLG_TMR1] = 1'b1;
        end
        // Other sources keep their flags for software
        default: begin
          hwClear = 13'h0000;
        end
      endcase
    end
  end

  // Pending per slot before any enable
  // Flags show even while masked
  always_comb begin
    rawReq = 11'h000;
    // Pins, timers: one flag a slot
    rawReq[flic_pkg::SRC_EXT0]     = q.flags[flic_pkg::FLG_EXT0];
    rawReq[flic_pkg::SRC_TMR0]     = q.flags[flic_pkg::FLG_TMR0];
    rawReq[flic_pkg::SRC_EXT1]     = q.flags[flic_pkg::FLG_EXT1];
    rawReq[flic_pkg::SRC_TMR1]     = q.flags[flic_pkg::FLG_TMR1];
    // Receive and transmit share one slot
    rawReq[flic_pkg::SRC_SERIAL]   = q.flags[flic_pkg::FLG_RX] | q.flags[flic_pkg::FLG_TX];
    // Brownout also needs its select bit
    rawReq[flic_pkg::SRC_BROWNOUT] = q.flags[flic_pkg::FLG_BROWNOUT] & brownoutIrqSelect;
    // State or timeout both request the two-wire slot
    rawReq[flic_pkg::SRC_TWOWIRE]  = q.flags[flic_pkg::FLG_TWSTATE] |
                                     q.flags[flic_pkg::FLG_TWTOUT];
    rawReq[flic_pkg::SRC_KEYPAD]   = q.flags[flic_pkg::FLG_KEYPAD];
    rawReq[flic_pkg::SRC_TMR2]     = q.flags[flic_pkg::FLG_TMR2];
    rawReq[flic_pkg::SRC_WDOG]     = q.flags[flic_pkg::FLG_WDOG];
    rawReq[flic_pkg::SRC_CAPTURE]  = q.flags[flic_pkg::FLG_CAPTURE];
  end

  // Global low withdraws all offers
  // Masks act on requests, not flags
  // Per-source enables and global gate
  assign resBus.req = rawReq & srcIrqEnable & {11{globalIrqEnable}};

  // Two priority bits per source give four levels
  // Level 3 is the highest
  generate
    for (genvar s = 0; s < flic_pkg::NUM_SRC; s++) begin : g_lvl
      assign resBus.lvl[2*s +: 2] = {prioHigh[s], prioLow[s]};
    end
  endgenerate

  // Highest level now in service; lower ones wait
  // Levels nest; top bit is the floor
  always_comb begin
    resBus.floorValid = |q.inSvc;
    resBus.floorLvl   = 2'h0;
    for (int l = 0; l < flic_pkg::NUM_LVL; l++) begin
      if (q.inSvc[l]) begin
        resBus.floorLvl = 2'(l);
      end
    end
  end

  // Return ends the highest active level only
  // Nothing in service: no change
  // Lower levels stay open
  always_comb begin
    svcNext = q.inSvc;
    if (irqReturn && resBus.floorValid) begin
      svcNext[resBus.floorLvl] = 1'b0;
    end
  end

  // Next-state for flags, service stack and offer
  // Return clears first, then ack sets
  always_comb begin
    d = q;
    // A set in the same cycle as a clear wins
    d.flags = (q.flags & ~flagSwClear & ~hwClear) | setEv;
    // Level mode mirrors the pin; vectoring cannot clear it
    if (extZeroTriggerType != flic_pkg::TRIG_EDGE) begin
      d.flags[flic_pkg::FLG_EXT0] = ~sampled[flic_pkg::PIN_EXT0];
    end
    if (extOneTriggerType != flic_pkg::TRIG_EDGE) begin
      d.flags[flic_pkg::FLG_EXT1] = ~sampled[flic_pkg::PIN_EXT1];
    end
    d.inSvc = svcNext;
    // Entered level goes in service
    if (ackTake) begin
      d.inSvc[q.lvl] = 1'b1;
    end
    // Drop the offer for one cycle after a take so stale flags settle
    d.req = resBus.hit && !ackTake;
    // Vector, level track the winner
    if (resBus.hit) begin
      d.idx = resBus.hitIdx;
      d.lvl = resBus.hitLvl;
      d.vec = flic_pkg::flic_vector(resBus.hitIdx);
    end
  end

  // One register stage for all controller state
  // Stall freezes all; pulses lost
  always_ff @(posedge ref_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      q <= '{flic_pkg::FLAG_RST, flic_pkg::SVC_RST, 1'b0, flic_pkg::VEC_RST, 2'h0, 4'h0};
    end else if (clkEn) begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  // Vector, level valid with irqReq
  // Flags and levels readable always
  assign irqReq          = q.req;
  assign irqVector       = q.vec;
  assign irqLevel        = q.lvl;
  assign irqFlags        = q.flags;
  assign inServiceLevels = q.inSvc;

endmodule

// file: test/flic_props.sv
`timescale 1ns/1ps
// Port-level checks on the interrupt controller
module flic_props (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        clkEn,
  input wire logic        extZeroTriggerType,
  input wire logic        brownoutIrqSelect,
  input wire logic        timerZeroOverflow,
  input wire logic        timerTwoEvent,
  input wire logic        captureEvent,
  input wire logic        globalIrqEnable,
  input wire logic [10:0] srcIrqEnable,
  input wire logic [12:0] flagSwClear,
  input wire logic        irqAck,
  input wire logic        irqReq,
  input wire logic [15:0] irqVector,
  input wire logic [1:0]  irqLevel,
  input wire logic [12:0] irqFlags,
  input wire logic [3:0]  inServiceLevels
);
  // Flags only software clears: serial, brownout, two-wire, keypad and up
  localparam logic [12:0] SW_ONLY = 13'h1ff0;
  // Watched event pulses placed at their flag positions
  wire logic [12:0] evtBits = {captureEvent, 1'b0, timerTwoEvent, 8'h00, timerZeroOverflow, 1'b0};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_evtSet;
    clkEn |=> ($past(evtBits) & ~irqFlags) == 13'h0000;
  endproperty
  property p_swOnly;
    clkEn |=> ($past(irqFlags) & ~$past(flagSwClear) & SW_ONLY & ~irqFlags) == 13'h0000;
  endproperty
  property p_tmrClear;
    clkEn && irqAck && irqReq && irqVector == flic_pkg::VEC_TMR0 && !timerZeroOverflow
      |=> !irqFlags[1];
  endproperty
  property p_edgeClear;
    clkEn && irqAck && irqReq && irqVector == flic_pkg::VEC_EXT0 && extZeroTriggerType
      |=> !irqFlags[0];
  endproperty
  property p_ackTake;
    clkEn && irqAck && irqReq |=> !irqReq && inServiceLevels[$past(irqLevel)];
  endproperty
  // An offer never sits at or below a level already in service
  property p_preempt;
    irqReq |-> (inServiceLevels >> irqLevel) == 4'h0;
  endproperty
  property p_gGate;
    clkEn && !globalIrqEnable |=> !irqReq;
  endproperty
  property p_brownGate;
    $past(clkEn) && irqReq && irqVector == flic_pkg::VEC_BROWNOUT
      |-> $past(brownoutIrqSelect) && $past(srcIrqEnable[5]) && $past(globalIrqEnable);
  endproperty
  property p_vecSlot;
    irqReq |-> irqVector[2:0] == 3'h3 && irqVector <= flic_pkg::VEC_CAPTURE
      && irqVector != flic_pkg::VEC_SPARE0 && irqVector != flic_pkg::VEC_SPARE1;
  endproperty

  a_evtSet: assert property (p_evtSet) else $error("event flag not set");
  a_swOnly: assert property (p_swOnly) else $error("flag lost");
  a_tmrClear: assert property (p_tmrClear) else $error("timer flag kept");
  a_edgeClear: assert property (p_edgeClear) else $error("edge flag kept");
  a_ackTake: assert property (p_ackTake) else $error("ack not taken");
  a_preempt: assert property (p_preempt) else $error("offer not above service");
  a_gGate: assert property (p_gGate) else $error("request while gated");
  a_brownGate: assert property (p_brownGate) else $error("brownout ungated");
  a_vecSlot: assert property (p_vecSlot) else $error("bad vector");

  c_ack: cover property (irqAck && irqReq);
  c_nest: cover property (inServiceLevels == 4'h9);
  c_level: cover property (irqReq && irqVector == flic_pkg::VEC_EXT1);
endmodule

bind flic_top flic_props u_props (.ref_clk, .rst_b, .clkEn, .extZeroTriggerType,
  .brownoutIrqSelect, .timerZeroOverflow, .timerTwoEvent, .captureEvent, .globalIrqEnable,
  .srcIrqEnable, .flagSwClear, .irqAck, .irqReq, .irqVector, .irqLevel, .irqFlags,
  .inServiceLevels);

// file: test/flic_core_model.sv
`timescale 1ns/1ps
// Core stand-in: takes offers, ends services by itself
module flic_core_model (
  input  wire logic        ref_clk,
  input  wire logic        irqReq,
  input  wire logic [15:0] irqVector,
  input  wire logic        ackOn,
  input  wire logic [3:0]  ackWait,
  input  wire logic        retOn,
  output logic             irqAck,
  output logic             irqReturn,
  output logic      [15:0] takenVec,
  output logic      [7:0]  nTaken
);
  logic [7:0] nRet; // Services ended
  initial begin
    irqAck = 1'b0;
    irqReturn = 1'b0;
    takenVec = 16'h0000;
    nTaken = 8'h00;
    nRet = 8'h00;
  end
  // A slow core may see the offer vanish; its ack is then ignored
  always begin
    @(posedge ref_clk);
    if (ackOn && irqReq) begin
      repeat (ackWait) @(posedge ref_clk);
      irqAck <= 1'b1;
      @(posedge ref_clk);
      irqAck <= 1'b0;
      if (irqReq) begin // Vectoring happens here
        takenVec <= irqVector;
        nTaken <= nTaken + 8'h01;
      end
    end
  end
  // One return per open service
  always begin
    @(posedge ref_clk);
    if (retOn && nTaken != nRet) begin
      repeat (3) @(posedge ref_clk);
      irqReturn <= 1'b1;
      @(posedge ref_clk);
      irqReturn <= 1'b0;
      nRet <= nRet + 8'h01;
    end
  end
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        ref_clk, rst_b, machCycle, brown, brownSel, gEn, ackOn, retOn, clkEn;
  logic        irqReq, irqAck, irqReturn;
  logic [1:0]  mcCnt, extPin, trig, irqLevel; // Pins and trigger types: bit 1 = pin one
  logic [7:0]  keys, keyEn, nTaken;
  logic [8:0]  evt;                           // Pulses in EVEC order
  logic [10:0] srcEn, pLo, pHi;
  logic [12:0] swClr, irqFlags;
  logic [3:0]  ackWait, inSvc;
  logic [15:0] irqVector, takenVec;
  int          mismatches, n_checks;
  localparam logic [15:0] EVEC [9] = '{flic_pkg::VEC_TMR0, flic_pkg::VEC_TMR1,
    flic_pkg::VEC_TMR2, flic_pkg::VEC_WDOG, flic_pkg::VEC_SERIAL, flic_pkg::VEC_SERIAL,
    flic_pkg::VEC_TWOWIRE, flic_pkg::VEC_TWOWIRE, flic_pkg::VEC_CAPTURE};
  localparam int EFLG [9] = '{1, 3, 10, 11, 4, 5, 7, 8, 12};

  flic_top dut (.ref_clk, .rst_b, .clkEn, .machCycle, .extIrqPinZero(extPin[0]),
    .extIrqPinOne(extPin[1]), .extZeroTriggerType(trig[0]), .extOneTriggerType(trig[1]),
    .keypadPins(keys), .keypadIrqEnable(keyEn), .brownoutDetect(brown),
    .brownoutIrqSelect(brownSel), .timerZeroOverflow(evt[0]), .timerOneOverflow(evt[1]),
    .timerTwoEvent(evt[2]), .watchdogTimeout(evt[3]), .serialReceiveDone(evt[4]),
    .serialTransmitDone(evt[5]), .twowireStatusNew(evt[6]), .twowireCounterOverflow(evt[7]),
    .captureEvent(evt[8]), .globalIrqEnable(gEn), .srcIrqEnable(srcEn), .prioLow(pLo),
    .prioHigh(pHi), .flagSwClear(swClr), .irqAck, .irqReturn, .irqReq, .irqVector,
    .irqLevel, .irqFlags, .inServiceLevels(inSvc));
  flic_core_model core (.ref_clk, .irqReq, .irqVector, .ackOn, .ackWait, .retOn, .irqAck,
    .irqReturn, .takenVec, .nTaken);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Machine cycle of four clocks
  always @(posedge ref_clk) begin
    mcCnt <= mcCnt + 2'h1;
    machCycle <= (mcCnt == 2'h3);
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic fire(input logic [8:0] m);
    @(posedge ref_clk) evt <= m;
    @(posedge ref_clk) evt <= 9'h000;
    #1;
  endtask
  task automatic clr(input int f);
    @(posedge ref_clk) swClr[f] <= 1'b1;
    @(posedge ref_clk) swClr <= 13'h0000;
    #1;
    chk("cleared flag", 1'b0, irqFlags[f]);
  endtask
  // Lets the core take one offer, bounded wait
  task automatic take(input string what, input logic [15:0] vec);
    int n0, i;
    n0 = nTaken;
    i = 0;
    @(posedge ref_clk) ackOn <= 1'b1;
    while (nTaken == n0 && i < 60) begin
      tick(1);
      i++;
    end
    @(posedge ref_clk) ackOn <= 1'b0;
    #1;
    chk(what, vec, takenVec);
    chk("take count", 16'(n0 + 1), 16'(nTaken));
  endtask
  task automatic s_events();
    for (int i = 0; i < 9; i++) begin
      fire(9'h001 << i);
      chk("event flag", 1'b1, irqFlags[EFLG[i]]);
      take("event vector", EVEC[i]);
      chk("flag after vectoring", i > 1, irqFlags[EFLG[i]]);
      clr(EFLG[i]);
    end
  endtask
  task automatic s_gate();
    @(posedge ref_clk) gEn <= 1'b0;
    fire(9'h002);
    tick(4);
    chk("gated request", 1'b0, irqReq);
    @(posedge ref_clk) gEn <= 1'b1;
    srcEn[9] <= 1'b0;
    take("ungated vector", flic_pkg::VEC_TMR1);
    tick(8);
    fire(9'h008);
    tick(4);
    chk("watchdog disabled", 1'b0, irqReq);
    @(posedge ref_clk) srcEn[9] <= 1'b1;
    take("watchdog vector", flic_pkg::VEC_WDOG);
    clr(11);
  endtask
  task automatic s_pins();
    @(posedge ref_clk) extPin[0] <= 1'b0; // Held many machine cycles
    take("edge vector", flic_pkg::VEC_EXT0);
    chk("edge flag cleared", 1'b0, irqFlags[0]);
    tick(16);
    chk("held pin no edge", 1'b0, irqReq);
    @(posedge ref_clk) extPin[0] <= 1'b1;
    keyEn <= 8'hdf;
    keys <= 8'hdf;
    tick(12);
    chk("disabled key", 1'b0, irqFlags[9]);
    @(posedge ref_clk) keys <= 8'hdb;
    take("keypad vector", flic_pkg::VEC_KEYPAD);
    chk("keypad flag kept", 1'b1, irqFlags[9]);
    @(posedge ref_clk) keys <= 8'hff;
    brownSel <= 1'b0;
    brown <= 1'b1;
    clr(9);
    tick(12);
    chk("brownout unselected", 1'b0, irqReq);
    @(posedge ref_clk) brownSel <= 1'b1;
    take("brownout vector", flic_pkg::VEC_BROWNOUT);
    @(posedge ref_clk) brown <= 1'b0;
    tick(8);
    clr(6);
  endtask
  task automatic s_level();
    @(posedge ref_clk) trig[1] <= 1'b0;
    extPin[1] <= 1'b0; // Source holds the pin until served
    take("level vector", flic_pkg::VEC_EXT1);
    chk("level flag kept", 1'b1, irqFlags[2]);
    take("level again", flic_pkg::VEC_EXT1);
    @(posedge ref_clk) extPin[1] <= 1'b1;
    tick(12);
    chk("level flag follows pin", 1'b0, irqFlags[2]);
    @(posedge ref_clk) trig[1] <= 1'b1;
  endtask
  task automatic s_nest();
    tick(8);
    @(posedge ref_clk) clkEn <= 1'b0;
    fire(9'h001);
    chk("frozen event", 1'b0, irqFlags[1]);
    @(posedge ref_clk) clkEn <= 1'b1;
    @(posedge ref_clk) retOn <= 1'b0;
    pHi[8] <= 1'b1;
    pLo[8] <= 1'b1;
    fire(9'h002);
    take("low level first", flic_pkg::VEC_TMR1);
    fire(9'h004);
    tick(1);
    chk("offered level", 2'h3, irqLevel);
    take("higher preempts", flic_pkg::VEC_TMR2);
    chk("nested levels", 4'h9, inSvc);
    clr(10);
    fire(9'h001);
    tick(6);
    chk("lower held off", 1'b0, irqReq);
    @(posedge ref_clk) retOn <= 1'b1;
    ackWait <= 4'h3;
    take("after returns", flic_pkg::VEC_TMR0);
    tick(8);
    @(posedge ref_clk) pHi[8] <= 1'b0;
    pLo[8] <= 1'b0;
    fire(9'h003);
    take("tie low slot", flic_pkg::VEC_TMR0);
    take("tie next slot", flic_pkg::VEC_TMR1);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    {rst_b, mcCnt, machCycle, brown, evt, pLo, pHi, swClr, ackOn, ackWait} = '0;
    {extPin, trig, keys, keyEn, srcEn, brownSel, gEn, retOn, clkEn} = '1;
    mismatches = 0;
    n_checks = 0;
    tick(20);
    @(posedge ref_clk) rst_b <= 1'b1;
    tick(3);
    chk("flags after reset", 13'h0000, irqFlags);
    s_events();
    s_gate();
    s_pins();
    s_level();
    s_nest();
    conclude();
  end
  // Hang guard, well beyond the few hundred cycles needed
  initial begin
    #160000;
    mismatches++;
    conclude();
  end
endmodule
